// [hdl/mss_sequencer.v]
// Startup sequencer for a four-phase buck controller: delay timer, soft-start,
// phase detection, per-phase slots, latchoff timer and command registers.
// Assumes a modulator drives per-phase requests and strap pins reach drive_in.
`timescale 1ns/1ps
`include "mss_regs.vh"

module mss_sequencer #(
   parameter DELAY_STEP_CYC = `MSS_DELAY_STEP_CYC,
   parameter STEP_BASE_CYC = `MSS_STEP_BASE_CYC,
   parameter MASK_CYC = `MSS_MASK_CYC
) (
   input wire mclk,
   input wire rst_b,
   input wire enable,
   input wire supply_ok,
   input wire over_limit,
   input wire [7:0] processor_voltage_code,
   input wire cmd_wr,
   input wire [7:0] cmd_code,
   input wire [7:0] cmd_wdata,
   output reg [7:0] cmd_rdata,
   input wire [3:0] pwm_request,
   input wire [3:0] drive_in,
   output reg [3:0] phase_drive,
   output reg [3:0] phase_drive_oe_b,
   output reg [2:0] phase_sink_en,
   output reg [3:0] phase_slot,
   output reg [2:0] phase_count,
   output reg [7:0] dac_target,
   output reg [7:0] positioning_scale,
   output reg output_good,
   output reg latched_off,
   output reg [3:0] seq_state
);

   // =========================================
   // States
   localparam ST_IDLE = 4'd0;
   localparam ST_FIRST_DELAY = 4'd1;
   localparam ST_DETECT = 4'd2;
   localparam ST_BOOT_RAMP = 4'd3;
   localparam ST_BOOT_HOLD = 4'd4;
   localparam ST_CODE_RAMP = 4'd5;
   localparam ST_MASK = 4'd6;
   localparam ST_GOOD_BLANKING = 4'd7;
   localparam ST_RUN = 4'd8;
   localparam ST_LATCHED = 4'd9;

   // Timer bases held at the widths of the counters they feed
   localparam [21:0] DELAY_STEP_W = DELAY_STEP_CYC;
   localparam [15:0] STEP_BASE_W = STEP_BASE_CYC;
   reg rst_s1_reg;
   reg rst_n_reg;
   reg [2:0] en_sync_reg, sup_sync_reg, ovl_sync_reg, pin_s1_reg, pin_s2_reg, pin_s3_reg;
   reg enable_reg, supply_reg, over_reg;
   reg [2:0] strap_reg;
   reg [7:0] delay_sel_reg, slew_sel_reg, ll_cal_reg, ll_set_reg, code_reg;
   reg [7:0] vid_s1_reg, vid_s2_reg, vid_s3_reg, vid_reg;
   reg [3:0] state_reg, state_next;
   reg [21:0] timer_reg, delay_len;
   reg [15:0] step_cnt_reg, step_len;
   reg [1:0] slot_reg;
   reg [5:0] ll_sum;
   reg [12:0] ll_prod;
   wire run_ok, timer_done, step_tick, drives_on;
   genvar gi;

   // =========================================
   // Reset release through two flip-flops
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   // =========================================
   // Pin synchronisers, change accepted when stages two and three agree
   always @(posedge mclk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         en_sync_reg <= 3'h0;
         sup_sync_reg <= 3'h0;
         ovl_sync_reg <= 3'h0;
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
         pin_s3_reg <= 3'h0;
         vid_s1_reg <= 8'h00;
         vid_s2_reg <= 8'h00;
         vid_s3_reg <= 8'h00;
         vid_reg <= 8'h00;
         enable_reg <= 1'b0;
         supply_reg <= 1'b0;
         over_reg <= 1'b0;
      end
      else
      begin
         en_sync_reg <= {en_sync_reg[1:0], enable};
         sup_sync_reg <= {sup_sync_reg[1:0], supply_ok};
         ovl_sync_reg <= {ovl_sync_reg[1:0], over_limit};
         pin_s1_reg <= drive_in[3:1];
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         vid_s1_reg <= processor_voltage_code;
         vid_s2_reg <= vid_s1_reg;
         vid_s3_reg <= vid_s2_reg;
         if (vid_s2_reg == vid_s3_reg)
            vid_reg <= vid_s3_reg;
         if (en_sync_reg[1] == en_sync_reg[2])
            enable_reg <= en_sync_reg[2];
         if (sup_sync_reg[1] == sup_sync_reg[2])
            supply_reg <= sup_sync_reg[2];
         if (ovl_sync_reg[1] == ovl_sync_reg[2])
            over_reg <= ovl_sync_reg[2];
      end
   end

   // =========================================
   // Command registers and read-back
   always @(posedge mclk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         delay_sel_reg <= `MSS_DELAY_RST;
         slew_sel_reg <= `MSS_SLEW_RST;
         ll_cal_reg <= `MSS_LL_RST;
         ll_set_reg <= `MSS_LL_RST;
         cmd_rdata <= 8'h00;
      end
      else
      begin
         if (cmd_wr)
         begin
            if (cmd_code == `MSS_CODE_DELAY)
               delay_sel_reg <= cmd_wdata;
            else if (cmd_code == `MSS_CODE_SLEW)
               slew_sel_reg <= cmd_wdata;
            else if (cmd_code == `MSS_CODE_LL_CAL)
               ll_cal_reg <= cmd_wdata;
            else if (cmd_code == `MSS_CODE_LL_SET)
               ll_set_reg <= cmd_wdata;
         end
         if (cmd_code == `MSS_CODE_DELAY)
            cmd_rdata <= delay_sel_reg;
         else if (cmd_code == `MSS_CODE_SLEW)
            cmd_rdata <= slew_sel_reg;
         else if (cmd_code == `MSS_CODE_LL_CAL)
            cmd_rdata <= ll_cal_reg;
         else if (cmd_code == `MSS_CODE_LL_SET)
            cmd_rdata <= ll_set_reg;
         else if (cmd_code == `MSS_CODE_STATUS)
            cmd_rdata <= {2'b00, latched_off, output_good, state_reg};
         else
            cmd_rdata <= 8'h00;
      end
   end

   // =========================================
   // Timer lengths from delay and slew codes
   always @*
   begin
      delay_len = DELAY_STEP_W * ({19'h00000, delay_sel_reg[`MSS_SEL_MSB:`MSS_SEL_LSB]} + 22'h1);
      if (state_reg == ST_RUN)
         delay_len = delay_len * {19'h00000, `MSS_LATCH_MULT};
      // cycles per step, base over odd divisor
      step_len = STEP_BASE_W / {12'h000, slew_sel_reg[`MSS_SEL_MSB:`MSS_SEL_LSB], 1'b1};
      ll_sum = {1'b0, ll_cal_reg[`MSS_LL_MSB:0]} + {1'b0, ll_set_reg[`MSS_LL_MSB:0]};
      ll_prod = ({7'h00, ll_sum} * 13'h0064) / `MSS_LL_SUM_MAX;
   end

   // Run condition and timer ends
   assign run_ok = enable_reg & supply_reg;
   assign timer_done = (timer_reg + 22'h1 >= delay_len);
   assign step_tick = (step_cnt_reg + 16'h1 >= step_len);
   // =========================================
   // Sequence state machine, next state
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            // start once enable and supply are good
            if (run_ok)
               state_next = ST_FIRST_DELAY;
         ST_FIRST_DELAY:
            if (timer_done)
               state_next = ST_DETECT;
         ST_DETECT:
            if (timer_reg[2:0] == `MSS_DETECT_CYC - 3'd1)
               state_next = ST_BOOT_RAMP;
         ST_BOOT_RAMP:
            if (dac_target == `MSS_BOOT_CODE)
               state_next = ST_BOOT_HOLD;
         ST_BOOT_HOLD:
            if (timer_done)
               state_next = ST_CODE_RAMP;
         ST_CODE_RAMP:
            if (dac_target == code_reg)
               state_next = ST_MASK;
         ST_MASK:
            if (timer_reg + 22'h1 >= MASK_CYC)
               state_next = ST_GOOD_BLANKING;
         ST_GOOD_BLANKING:
            if (timer_done)
               state_next = ST_RUN;
         ST_RUN:
            if (over_reg && timer_done)
               state_next = ST_LATCHED;
         ST_LATCHED:
            state_next = ST_LATCHED;
         default:
            state_next = ST_IDLE;
      endcase
      if (!run_ok)
         state_next = ST_IDLE;
   end

   // =========================================
   // Sequence registers: state, timer, DAC target, code sample, straps
   always @(posedge mclk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         state_reg <= ST_IDLE;
         timer_reg <= 22'h0;
         step_cnt_reg <= 16'h0;
         dac_target <= 8'h00;
         code_reg <= 8'h00;
         strap_reg <= 3'h0;
      end
      else
      begin
         state_reg <= state_next;
         // Timer restarts on every state change
         if (state_next != state_reg)
            timer_reg <= 22'h0;
         // latchoff counts only while over limit in run
         else if (state_reg == ST_RUN && !over_reg)
            timer_reg <= 22'h0;
         else
            timer_reg <= timer_reg + 22'h1;
         if (state_reg == ST_DETECT && pin_s2_reg == pin_s3_reg)
            strap_reg <= pin_s3_reg;
         else if (state_reg == ST_IDLE)
            strap_reg <= 3'h0;
         // sample processor code at end of hold
         if (state_reg == ST_BOOT_HOLD && timer_done)
            code_reg <= vid_reg;
         if (state_reg == ST_BOOT_RAMP || state_reg == ST_CODE_RAMP)
            step_cnt_reg <= step_tick ? 16'h0 : step_cnt_reg + 16'h1;
         else
            step_cnt_reg <= 16'h0;
         if (state_reg == ST_IDLE)
            dac_target <= 8'h00;
         else if (state_reg == ST_BOOT_RAMP && step_tick && dac_target != `MSS_BOOT_CODE)
            dac_target <= dac_target + 8'h01;
         // code ramp steps up or down
         else if (state_reg == ST_CODE_RAMP && step_tick)
         begin
            if (dac_target < code_reg)
               dac_target <= dac_target + 8'h01;
            else if (dac_target > code_reg)
               dac_target <= dac_target - 8'h01;
         end
      end
   end

   // =========================================
   // Phase count, slot rotation and status outputs
   always @(posedge mclk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         phase_count <= 3'd4;
         slot_reg <= 2'd0;
         phase_slot <= 4'h0;
         output_good <= 1'b0;
         latched_off <= 1'b0;
         seq_state <= ST_IDLE;
         positioning_scale <= 8'h00;
      end
      else
      begin
         if (strap_reg[0])
            phase_count <= 3'd1;
         else if (strap_reg[1])
            phase_count <= 3'd2;
         else if (strap_reg[2])
            phase_count <= 3'd3;
         else
            phase_count <= 3'd4;
         if ({1'b0, slot_reg} + 3'd1 >= phase_count)
            slot_reg <= 2'd0;
         else
            slot_reg <= slot_reg + 2'd1;
         phase_slot <= 4'h1 << slot_reg;
         output_good <= (state_reg == ST_RUN);
         latched_off <= (state_reg == ST_LATCHED);
         seq_state <= state_reg;
         positioning_scale <= `MSS_LL_MIN_PCT + ll_prod[7:0];
      end
   end
   // no pulses in detection or before
   assign drives_on = (state_reg >= ST_BOOT_RAMP) && (state_reg <= ST_RUN);
   // =========================================
   // Per-phase drive, enable and sink
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_phase
         always @(posedge mclk or negedge rst_n_reg)
         begin
            if (!rst_n_reg)
            begin
               phase_drive[gi] <= 1'b0;
               phase_drive_oe_b[gi] <= (gi == 0) ? 1'b0 : 1'b1;
            end
            else
            begin
               // each phase gated on its own request
               phase_drive[gi] <= drives_on & pwm_request[gi] & (gi < phase_count);
               // pin one always driven, low when idle
               if (gi == 0)
                  phase_drive_oe_b[gi] <= 1'b0;
               // strapped pins high impedance after detection
               else if (state_reg == ST_IDLE || state_reg == ST_FIRST_DELAY
                        || state_reg == ST_DETECT)
                  phase_drive_oe_b[gi] <= 1'b1;
               else
                  phase_drive_oe_b[gi] <= (gi >= phase_count);
            end
         end
      end
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_sink
         always @(posedge mclk or negedge rst_n_reg)
         begin
            if (!rst_n_reg)
               phase_sink_en[gi] <= 1'b0;
            else
               // weak sink before soft-start while enabled
               phase_sink_en[gi] <= enable_reg && (state_reg == ST_IDLE
                  || state_reg == ST_FIRST_DELAY || state_reg == ST_DETECT);
         end
      end
   endgenerate
endmodule

// [hdl/mss_regs.vh]
// Constants of the multiphase startup sequencer: command codes, fields, resets, timing.
// Assumes a 20 MHz master clock and a command port that writes one byte per code.
`ifndef MSS_REGS_VH
`define MSS_REGS_VH

// =========================================
// Command codes
`define MSS_CODE_DELAY 8'hD4
`define MSS_CODE_SLEW 8'hD5
`define MSS_CODE_LL_CAL 8'hDE
`define MSS_CODE_LL_SET 8'hDF
`define MSS_CODE_STATUS 8'hE0

// =========================================
// Fields and reset values
`define MSS_SEL_MSB 2
`define MSS_SEL_LSB 0
`define MSS_LL_MSB 4
`define MSS_DELAY_RST 8'h03
`define MSS_SLEW_RST 8'h02
`define MSS_LL_RST 8'h10

// =========================================
// Timing
`define MSS_CLK_KHZ 20000
`define MSS_DELAY_STEP_US 500
`define MSS_DELAY_STEP_CYC ((`MSS_DELAY_STEP_US * `MSS_CLK_KHZ) / 1000)
`define MSS_STEP_UV 6250
`define MSS_SLEW_MIN_MV_PER_MS 100
`define MSS_STEP_BASE_CYC ((`MSS_STEP_UV * `MSS_CLK_KHZ) / (`MSS_SLEW_MIN_MV_PER_MS * 1000))
`define MSS_MASK_US 250
`define MSS_MASK_CYC ((`MSS_MASK_US * `MSS_CLK_KHZ) / 1000)
`define MSS_DETECT_CYC 3'd6
`define MSS_LATCH_MULT 3'd4
`define MSS_BOOT_CODE 8'hA8
`define MSS_LL_MIN_PCT 8'h32
`define MSS_LL_SPAN_PCT 100
`define MSS_LL_SUM_MAX 13'h003E

`endif

// [dv/mss_sequencer_chk.sv]
// Port checker for the startup sequencer.
// Assumes binding to mss_sequencer, one clock, rst_b active low.
`timescale 1ns/1ps
module mss_sequencer_chk (
   input wire mclk,
   input wire rst_b,
   input wire enable,
   input wire [3:0] pwm_request,
   input wire [3:0] phase_drive,
   input wire [3:0] phase_drive_oe_b,
   input wire [2:0] phase_sink_en,
   input wire [3:0] phase_slot,
   input wire [2:0] phase_count,
   input wire [7:0] dac_target,
   input wire output_good,
   input wire latched_off,
   input wire [3:0] seq_state
);
   // ==========================================
   // Clocking
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   // ==========================================
   // Sequence properties
   property p_quiet;
      seq_state <= 4'h2 |-> phase_drive == 4'h0 && !phase_drive_oe_b[0];
   endproperty
   a_quiet: assert property (p_quiet) else $error("drive before ramp");
   property p_sink;
      seq_state == 4'h2 |-> phase_sink_en == 3'h7;
   endproperty
   a_sink: assert property (p_sink) else $error("no sink in detect");
   property p_drop;
      seq_state inside {[4'h3:4'h8]} |-> phase_sink_en == 3'h0;
   endproperty
   a_drop: assert property (p_drop) else $error("sink kept");
   property p_boot_step;
      seq_state == 4'h3 ##1 seq_state == 4'h3 |->
         dac_target == $past(dac_target) || dac_target == $past(dac_target) + 8'h01;
   endproperty
   a_boot_step: assert property (p_boot_step) else $error("bad boot step");
   property p_boot_level;
      seq_state == 4'h4 |-> dac_target == 8'hA8;
   endproperty
   a_boot_level: assert property (p_boot_level) else $error("hold off boot");
   property p_code_step;
      seq_state == 4'h5 ##1 seq_state == 4'h5 |->
         (dac_target - $past(dac_target)) inside {8'h00, 8'h01, 8'hFF};
   endproperty
   a_code_step: assert property (p_code_step) else $error("bad code step");
   property p_drive;
      seq_state inside {[4'h3:4'h8]} ##1 seq_state inside {[4'h3:4'h8]} |->
         phase_drive == ($past(pwm_request) & ~phase_drive_oe_b);
   endproperty
   a_drive: assert property (p_drive) else $error("drive mismatch");
   property p_slot;
      seq_state == 4'h8 ##1 seq_state == 4'h8 |->
         $onehot(phase_slot) && (phase_slot >> phase_count) == 4'h0 &&
         (($past(phase_slot) == (4'h1 << (phase_count - 3'h1))) ?
            phase_slot == 4'h1 : phase_slot == ($past(phase_slot) << 1));
   endproperty
   a_slot: assert property (p_slot) else $error("slot rotation wrong");
   property p_good;
      $rose(output_good) |-> $past(seq_state) == 4'h7;
   endproperty
   a_good: assert property (p_good) else $error("good outside run");
   property p_latch;
      $rose(latched_off) |-> $past(seq_state) == 4'h8;
   endproperty
   a_latch: assert property (p_latch) else $error("latch before run");
   property p_abort;
      $fell(enable) |-> ##[2:6] (seq_state == 4'h0 && dac_target == 8'h00 &&
         phase_drive == 4'h0);
   endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   // ==========================================
   // Coverage
   c_detect: cover property (seq_state == 4'h2 ##1 seq_state == 4'h3);
   c_run: cover property (seq_state == 4'h8);
   c_latch: cover property (latched_off);
endmodule

bind mss_sequencer mss_sequencer_chk u_chk (.mclk(mclk), .rst_b(rst_b), .enable(enable),
   .pwm_request(pwm_request), .phase_drive(phase_drive),
   .phase_drive_oe_b(phase_drive_oe_b), .phase_sink_en(phase_sink_en),
   .phase_slot(phase_slot), .phase_count(phase_count), .dac_target(dac_target),
   .output_good(output_good), .latched_off(latched_off), .seq_state(seq_state));

// [dv/mss_drive_model.sv]
// Drive pin model: strap ties, weak sink and floating pins.
// Assumes strap bit 0 is pin 2 and oe_b low means driven.
`timescale 1ns/1ps
module mss_drive_model (
   input wire mclk,
   input wire [3:0] phase_drive,
   input wire [3:0] phase_drive_oe_b,
   input wire [2:0] phase_sink_en,
   input wire [2:0] strap,
   output reg [3:0] drive_in
);
   reg flip_reg = 1'b0;
   integer k;
   // Floating level wanders each cycle
   always @(posedge mclk)
      flip_reg <= ~flip_reg;
   // Pin level from all parties
   always @*
   begin
      drive_in[0] = phase_drive_oe_b[0] ? flip_reg : phase_drive[0];
      for (k = 1; k < 4; k = k + 1)
         if (strap[k-1])
            drive_in[k] = 1'b1;
         else if (!phase_drive_oe_b[k])
            drive_in[k] = phase_drive[k];
         else if (phase_sink_en[k-1])
            drive_in[k] = 1'b0;
         else
            drive_in[k] = flip_reg ^ k[0];
   end
endmodule

// [dv/mss_sequencer_tb.sv]
// Testbench for the startup sequencer: commands, startup, straps, latchoff.
// Assumes shortened timer parameters and the drive pin model.
`timescale 1ns/1ps
module mss_sequencer_tb;
   localparam STEP = 20;
   reg mclk, rst_b, enable, supply_ok, over_limit, cmd_wr;
   reg [7:0] processor_voltage_code, cmd_code, cmd_wdata;
   reg [3:0] pwm_request;
   reg [2:0] strap;
   wire [7:0] cmd_rdata, dac_target, positioning_scale;
   wire [3:0] drive_in, phase_drive, phase_drive_oe_b, phase_slot, seq_state;
   wire [2:0] phase_sink_en, phase_count;
   wire output_good, latched_off;
   integer bad_count = 0, tests_run = 0, cycles = 0, i, n;
   // ==========================================
   // Design and pin model
   mss_sequencer #(.DELAY_STEP_CYC(STEP), .STEP_BASE_CYC(15), .MASK_CYC(10)) DUT (
      .mclk(mclk), .rst_b(rst_b), .enable(enable), .supply_ok(supply_ok),
      .over_limit(over_limit), .processor_voltage_code(processor_voltage_code),
      .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .cmd_rdata(cmd_rdata), .pwm_request(pwm_request), .drive_in(drive_in),
      .phase_drive(phase_drive), .phase_drive_oe_b(phase_drive_oe_b),
      .phase_sink_en(phase_sink_en), .phase_slot(phase_slot),
      .phase_count(phase_count), .dac_target(dac_target),
      .positioning_scale(positioning_scale), .output_good(output_good),
      .latched_off(latched_off), .seq_state(seq_state));
   mss_drive_model PTR (.mclk(mclk), .phase_drive(phase_drive),
      .phase_drive_oe_b(phase_drive_oe_b), .phase_sink_en(phase_sink_en),
      .strap(strap), .drive_in(drive_in));
   // ==========================================
   // Clock and watchdog
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: watchdog", $time);
         finish_test;
      end
   end
   // ==========================================
   // Tasks
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", tests_run, bad_count);
         if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp)
         begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task cyc(input integer c);
      repeat (c) @(negedge mclk);
   endtask
   task wr(input [7:0] c, input [7:0] d);
      begin
         @(negedge mclk);
         cmd_code = c;
         cmd_wdata = d;
         cmd_wr = 1'b1;
         @(negedge mclk);
         cmd_wr = 1'b0;
      end
   endtask
   task rd(input [7:0] c, input [7:0] exp);
      begin
         @(negedge mclk);
         cmd_code = c;
         cyc(2);
         chk(cmd_rdata, exp);
      end
   endtask
   // Cycles spent in one state
   task span(input [3:0] st, input [15:0] exp);
      begin
         n = 0;
         while (seq_state !== st) cyc(1);
         while (seq_state === st)
         begin
            n = n + 1;
            cyc(1);
         end
         chk(n, exp);
      end
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      rst_b = 1'b0; enable = 1'b0; supply_ok = 1'b1; over_limit = 1'b0;
      cmd_wr = 1'b0; cmd_code = 8'h00; cmd_wdata = 8'h00; pwm_request = 4'h0;
      processor_voltage_code = 8'hA8; strap = 3'h0;
      cyc(4);
      rst_b = 1'b1;
      cyc(4);
      chk(phase_count, 4);
      rd(8'hD4, 8'h03);
      rd(8'hD5, 8'h02);
      rd(8'hDE, 8'h10);
      rd(8'hDF, 8'h10);
      chk(positioning_scale, 101);
      wr(8'hDE, 8'h1F);
      wr(8'hDF, 8'h1F);
      cyc(3);
      chk(positioning_scale, 150);
      wr(8'hDE, 8'h00);
      wr(8'hDF, 8'h00);
      cyc(3);
      chk(positioning_scale, 50);
      wr(8'hE0, 8'hFF);
      rd(8'hE0, 8'h00);
      wr(8'h00, 8'h5A);
      rd(8'h00, 8'h00);
      wr(8'hD5, 8'h07);
      rd(8'hD5, 8'h07);
      // Startup with zero to three pins strapped, from pin 4 downward
      for (i = 0; i < 4; i = i + 1)
      begin
         strap = ~(3'h7 >> i);
         processor_voltage_code = 8'hA0 + {i[4:0], 3'h0};
         over_limit = (i == 1);
         wr(8'hD4, {7'h7C, i == 1});
         rd(8'hD4, {7'h7C, i == 1});
         enable = 1'b1;
         span(4'h1, (1 + (i == 1)) * STEP);
         chk(phase_sink_en, 3'h7);
         span(4'h2, 6);
         span(4'h4, (1 + (i == 1)) * STEP);
         chk(phase_count, 4 - i);
         chk(phase_drive_oe_b, {strap, 1'b0});
         span(4'h6, 10);
         span(4'h7, (1 + (i == 1)) * STEP);
         chk(dac_target, processor_voltage_code);
         cyc(1);
         chk(output_good, 1);
         chk(phase_sink_en, 0);
         chk(latched_off, 0);
         pwm_request = 4'hF;
         cyc(2);
         chk(phase_drive, ~{strap, 1'b0} & 4'hF);
         pwm_request = 4'h0;
         n = 0;
         while (i == 1 && latched_off !== 1'b1 && n < 400)
         begin
            n = n + 1;
            cyc(1);
         end
         if (i == 1)
            chk(n >= 150 && n <= 162, 1);
         while (phase_slot !== 4'h1) cyc(1);
         cyc(4 - i);
         chk(phase_slot, 1);
         enable = 1'b0;
         over_limit = 1'b0;
         while (seq_state !== 4'h0) cyc(1);
         chk(latched_off, 0);
         chk(dac_target, 0);
      end
      // Abort in mid-ramp, then restart
      enable = 1'b1;
      while (seq_state !== 4'h3) cyc(1);
      cyc(5);
      pwm_request = 4'hF;
      enable = 1'b0;
      while (seq_state !== 4'h0) cyc(1);
      chk(dac_target, 0);
      chk(phase_drive, 0);
      enable = 1'b1;
      span(4'h1, STEP);
      // Supply lockout in mid-ramp, then restart
      while (seq_state !== 4'h3) cyc(1);
      supply_ok = 1'b0;
      while (seq_state !== 4'h0) cyc(1);
      chk(dac_target, 0);
      chk(phase_drive, 0);
      supply_ok = 1'b1;
      span(4'h1, STEP);
      finish_test;
   end
endmodule
